// >>> logic/frpr_read_params.sv
// Read-parameter register pair, pin function select and read setup
// Operation
// - Keep non-volatile and volatile copies with the same eight-bit layout.
// - At power-up copy the non-volatile copy into the volatile copy.
// - Shared pin, SPI, quad enable 0: select bit 0 hold, 1 reset.
// - Quad enable 1 or quad command mode: ignore select, pin is data line 3.
// - Dedicated reset still enabled, SPI, quad enable 0: shared pin is hold.
// - Command 65h writes only the non-volatile copy.
// - Command C0h or 63h writes the volatile copy.
// - Burst field 00/01/10/11 means 8/16/32/64 bytes.
// - Wrap bit 0 wraps at array end; 1 wraps at burst boundary.
// - Dummy field bits 6..3; 1 to 15 literal, 0 means command default.
// - After reset or fresh part all parameter bits are zero.
// - Defaults: 8 single/dual/quad output, 6 quad command and quad I/O, 4 dual I/O.
// - Identifier, parameter-table and information-row reads follow fast read 0Bh.
// - Dual I/O double-rate read refused in quad command mode.
`timescale 1ns/100ps
`default_nettype none
module frpr_read_params #(
   parameter bit         HAS_DEDICATED_RESET = 1'b0,
   parameter logic [7:0] UID_READ_CMD        = 8'hF1,
   parameter logic [7:0] SFDP_READ_CMD       = 8'hF2,
   parameter logic [7:0] INFO_ROW_READ_CMD   = 8'hF3
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire logic                      sck,
   input  wire logic                      csN,
   input  wire logic [3:0]                dataIn,
   input  wire logic                      quadEnableFlag,
   input  wire logic                      quadCommandMode,
   input  wire logic                      dedicatedResetDisable,
   input  wire logic                      readStart,
   input  wire logic [7:0]                readCmd,
   output var frpr_pkg::frpr_params_type  nvParams,
   output var frpr_pkg::frpr_params_type  vParams,
   output logic                           loadBusy,
   output logic                           writeDone,
   output logic [3:0]                     rdDummy,
   output logic                           rdWrapEn,
   output logic [6:0]                     rdBurstBytes,
   output logic                           rdRefused,
   output logic                           sharedPinIsData3,
   output logic                           sharedPinIsReset
);
   frpr_pkg::frpr_word_type   linkWord;
   logic                      linkToggle;
   logic                      togMeta_q;
   logic                      togSync_q;
   logic                      togSeen_q;
   logic                      togSeen_d;
   logic                      linkEvent;
   frpr_pkg::frpr_state_type  state_q;
   frpr_pkg::frpr_state_type  state_d;
   frpr_pkg::frpr_params_type nv_q;
   frpr_pkg::frpr_params_type nv_d;
   frpr_pkg::frpr_params_type v_q;
   frpr_pkg::frpr_params_type v_d;
   logic                      writeDone_q;
   logic                      writeDone_d;
   logic [3:0]                rdDummy_q;
   logic [3:0]                rdDummy_d;
   logic                      rdWrapEn_q;
   logic                      rdWrapEn_d;
   logic [6:0]                rdBurst_q;
   logic [6:0]                rdBurst_d;
   logic                      rdRefused_q;
   logic                      rdRefused_d;
   logic                      pinData3_q;
   logic                      pinData3_d;
   logic                      pinReset_q;
   logic                      pinReset_d;
   logic                      loadBusy_q;
   logic                      loadBusy_d;

   frpr_link_rx u_link (
      .sck             (sck),
      .rst             (rst),
      .csN             (csN),
      .dataIn          (dataIn),
      .quadCommandMode (quadCommandMode),
      .wordOut         (linkWord),
      .wordToggle      (linkToggle)
   );

   // Command default or programmed dummy count
   function automatic logic [3:0] dummyFor(input logic [7:0] cmd,
                                           input logic       quadMode,
                                           input logic [3:0] field);
      logic [3:0] def;
      def = frpr_pkg::DUMMY_NONE;
      if (cmd == frpr_pkg::CMD_FAST_RD || cmd == frpr_pkg::CMD_FAST_RD_DR ||
          cmd == UID_READ_CMD || cmd == SFDP_READ_CMD ||
          cmd == INFO_ROW_READ_CMD) begin
         def = quadMode ? frpr_pkg::DUMMY_DEF_QUAD : frpr_pkg::DUMMY_DEF_WIDE;
      end else if (cmd == frpr_pkg::CMD_DUAL_OUT || cmd == frpr_pkg::CMD_QUAD_OUT) begin
         def = frpr_pkg::DUMMY_DEF_WIDE;
      end else if (cmd == frpr_pkg::CMD_DUAL_IO || cmd == frpr_pkg::CMD_DUAL_IO_DR) begin
         def = frpr_pkg::DUMMY_DEF_DUAL;
      end else if (cmd == frpr_pkg::CMD_QUAD_IO || cmd == frpr_pkg::CMD_QUAD_IO_DR) begin
         def = frpr_pkg::DUMMY_DEF_QUAD;
      end
      if (def == frpr_pkg::DUMMY_NONE) begin
         dummyFor = frpr_pkg::DUMMY_NONE;
      end else if (field != frpr_pkg::DUMMY_NONE) begin
         dummyFor = field;
      end else begin
         dummyFor = def;
      end
   endfunction

   // Burst field to byte count
   function automatic logic [6:0] burstBytes(input logic [1:0] code);
      unique case (code)
         frpr_pkg::BURST_CODE_8:  burstBytes = frpr_pkg::BURST_BYTES_8;
         frpr_pkg::BURST_CODE_16: burstBytes = frpr_pkg::BURST_BYTES_16;
         frpr_pkg::BURST_CODE_32: burstBytes = frpr_pkg::BURST_BYTES_32;
         frpr_pkg::BURST_CODE_64: burstBytes = frpr_pkg::BURST_BYTES_64;
      endcase
   endfunction

   // Link toggle crossing
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         togMeta_q <= 1'b0;
         togSync_q <= 1'b0;
      end else begin
         togMeta_q <= linkToggle;
         togSync_q <= togMeta_q;
      end
   end

   assign linkEvent = togSync_q ^ togSeen_q;

   // Register pair, power-up reload, command writes
   always_comb begin
      state_d     = state_q;
      nv_d        = nv_q;
      v_d         = v_q;
      togSeen_d   = togSeen_q;
      writeDone_d = 1'b0;
      loadBusy_d  = 1'b0;
      unique case (state_q)
         frpr_pkg::ST_LOAD: begin
            v_d     = nv_q;
            state_d = frpr_pkg::ST_RUN;
         end
         frpr_pkg::ST_RUN: begin
            if (linkEvent) begin
               togSeen_d = togSync_q;
               if (linkWord.cmd == frpr_pkg::CMD_SET_NV) begin
                  nv_d        = linkWord.data;
                  writeDone_d = 1'b1;
               end else if (linkWord.cmd == frpr_pkg::CMD_SET_V_A ||
                            linkWord.cmd == frpr_pkg::CMD_SET_V_B) begin
                  v_d         = linkWord.data;
                  writeDone_d = 1'b1;
               end
            end
         end
      endcase
   end

   // Parameters held in flip-flops, both copies zero after reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q     <= frpr_pkg::ST_LOAD;
         nv_q        <= frpr_pkg::PARAM_RESET;
         v_q         <= frpr_pkg::PARAM_RESET;
         togSeen_q   <= 1'b0;
         writeDone_q <= 1'b0;
         loadBusy_q  <= 1'b1;
      end else begin
         state_q     <= state_d;
         nv_q        <= nv_d;
         v_q         <= v_d;
         togSeen_q   <= togSeen_d;
         writeDone_q <= writeDone_d;
         loadBusy_q  <= loadBusy_d;
      end
   end

   // Read setup latched at read start from the volatile copy
   always_comb begin
      rdDummy_d   = rdDummy_q;
      rdWrapEn_d  = rdWrapEn_q;
      rdBurst_d   = rdBurst_q;
      rdRefused_d = rdRefused_q;
      if (readStart && state_q == frpr_pkg::ST_RUN) begin
         rdDummy_d   = dummyFor(readCmd, quadCommandMode, v_q.dummy);
         rdWrapEn_d  = v_q.wrapEn;
         rdBurst_d   = burstBytes(v_q.burstLen);
         rdRefused_d = 1'b0;
         if (quadCommandMode && readCmd == frpr_pkg::CMD_DUAL_IO_DR) begin
            rdRefused_d = 1'b1;
            rdDummy_d   = frpr_pkg::DUMMY_NONE;
         end
      end
   end

   // Shared hold/reset pin function
   always_comb begin
      pinData3_d = 1'b0;
      pinReset_d = 1'b0;
      if (quadEnableFlag || quadCommandMode) begin
         pinData3_d = 1'b1;
      end else if (HAS_DEDICATED_RESET && !dedicatedResetDisable) begin
         pinReset_d = 1'b0;
      end else begin
         pinReset_d = v_q.pinSel;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdDummy_q   <= frpr_pkg::DUMMY_NONE;
         rdWrapEn_q  <= 1'b0;
         rdBurst_q   <= frpr_pkg::BURST_BYTES_8;
         rdRefused_q <= 1'b0;
         pinData3_q  <= 1'b0;
         pinReset_q  <= 1'b0;
      end else begin
         rdDummy_q   <= rdDummy_d;
         rdWrapEn_q  <= rdWrapEn_d;
         rdBurst_q   <= rdBurst_d;
         rdRefused_q <= rdRefused_d;
         pinData3_q  <= pinData3_d;
         pinReset_q  <= pinReset_d;
      end
   end

   assign nvParams         = nv_q;
   assign vParams          = v_q;
   assign loadBusy         = loadBusy_q;
   assign writeDone        = writeDone_q;
   assign rdDummy          = rdDummy_q;
   assign rdWrapEn         = rdWrapEn_q;
   assign rdBurstBytes     = rdBurst_q;
   assign rdRefused        = rdRefused_q;
   assign sharedPinIsData3 = pinData3_q;
   assign sharedPinIsReset = pinReset_q;

   // Checks
   default clocking cbSys @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic runStart;
   assign runStart = readStart && state_q == frpr_pkg::ST_RUN;

   sequence s_volatileWrite;
      linkEvent && state_q == frpr_pkg::ST_RUN &&
      (linkWord.cmd == frpr_pkg::CMD_SET_V_A || linkWord.cmd == frpr_pkg::CMD_SET_V_B);
   endsequence

   sequence s_nvWrite;
      linkEvent && state_q == frpr_pkg::ST_RUN && linkWord.cmd == frpr_pkg::CMD_SET_NV;
   endsequence

   property p_load_copy;
      state_q == frpr_pkg::ST_LOAD |=> v_q == $past(nv_q) && state_q == frpr_pkg::ST_RUN;
   endproperty
   a_load_copy: assert property (p_load_copy) else $error("power-up reload missed");

   property p_nv_write;
      s_nvWrite |=> nv_q == $past(linkWord.data) && v_q == $past(v_q) && writeDone_q;
   endproperty
   a_nv_write: assert property (p_nv_write) else $error("nv write wrong");

   property p_v_write;
      s_volatileWrite |=> v_q == $past(linkWord.data) && nv_q == $past(nv_q) && writeDone_q;
   endproperty
   a_v_write: assert property (p_v_write) else $error("volatile write wrong");

   property p_burst64;
      runStart && v_q.burstLen == frpr_pkg::BURST_CODE_64 |=>
         rdBurst_q == frpr_pkg::BURST_BYTES_64;
   endproperty
   a_burst64: assert property (p_burst64) else $error("burst decode wrong");

   property p_wrap;
      runStart |=> rdWrapEn_q == $past(v_q.wrapEn);
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap enable not taken");

   property p_dummy_field;
      runStart && readCmd == frpr_pkg::CMD_FAST_RD && v_q.dummy != frpr_pkg::DUMMY_NONE |=>
         rdDummy_q == $past(v_q.dummy);
   endproperty
   a_dummy_field: assert property (p_dummy_field) else $error("dummy field ignored");

   property p_dummy_dual;
      runStart && readCmd == frpr_pkg::CMD_DUAL_IO && !quadCommandMode &&
      v_q.dummy == frpr_pkg::DUMMY_NONE |=> rdDummy_q == frpr_pkg::DUMMY_DEF_DUAL;
   endproperty
   a_dummy_dual: assert property (p_dummy_dual) else $error("dual io default wrong");

   property p_pin_data3;
      quadEnableFlag || quadCommandMode |=> pinData3_q && !pinReset_q;
   endproperty
   a_pin_data3: assert property (p_pin_data3) else $error("pin not data line");

   property p_pin_select;
      !quadEnableFlag && !quadCommandMode &&
      !(HAS_DEDICATED_RESET && !dedicatedResetDisable) |=> pinReset_q == $past(v_q.pinSel);
   endproperty
   a_pin_select: assert property (p_pin_select) else $error("pin select wrong");

   property p_refuse;
      runStart && quadCommandMode && readCmd == frpr_pkg::CMD_DUAL_IO_DR |=>
         rdRefused_q ##1 rdRefused_q || $past(readStart);
   endproperty
   a_refuse: assert property (p_refuse) else $error("dual io double rate taken");

   property p_new_value_used;
      s_volatileWrite ##1 runStart && readCmd == frpr_pkg::CMD_FAST_RD |=>
         rdWrapEn_q == $past(v_q.wrapEn, 1) && rdBurst_q == burstBytes($past(v_q.burstLen));
   endproperty
   a_new_value_used: assert property (p_new_value_used) else $error("stale params used");
endmodule
`default_nettype wire

// >>> logic/frpr_pkg.sv
// Read-parameter register constants, encodings and carrier types
package frpr_pkg;
   localparam int          PARAM_W        = 8;
   localparam logic [7:0]  PARAM_RESET    = 8'h00;
   localparam int          BURST_LO_POS   = 0;
   localparam int          BURST_HI_POS   = 1;
   localparam int          WRAP_POS       = 2;
   localparam int          DUMMY_LSB_POS  = 3;
   localparam int          DUMMY_MSB_POS  = 6;
   localparam int          PIN_SEL_POS    = 7;

   localparam logic [7:0]  CMD_SET_NV     = 8'h65;
   localparam logic [7:0]  CMD_SET_V_A    = 8'hC0;
   localparam logic [7:0]  CMD_SET_V_B    = 8'h63;
   localparam logic [7:0]  CMD_FAST_RD    = 8'h0B;
   localparam logic [7:0]  CMD_FAST_RD_DR = 8'h0D;
   localparam logic [7:0]  CMD_DUAL_OUT   = 8'h3B;
   localparam logic [7:0]  CMD_DUAL_IO    = 8'hBB;
   localparam logic [7:0]  CMD_DUAL_IO_DR = 8'hBD;
   localparam logic [7:0]  CMD_QUAD_OUT   = 8'h6B;
   localparam logic [7:0]  CMD_QUAD_IO    = 8'hEB;
   localparam logic [7:0]  CMD_QUAD_IO_DR = 8'hED;

   localparam logic [3:0]  DUMMY_NONE     = 4'h0;
   localparam logic [3:0]  DUMMY_DEF_WIDE = 4'h8;
   localparam logic [3:0]  DUMMY_DEF_QUAD = 4'h6;
   localparam logic [3:0]  DUMMY_DEF_DUAL = 4'h4;

   localparam logic [1:0]  BURST_CODE_8   = 2'h0;
   localparam logic [1:0]  BURST_CODE_16  = 2'h1;
   localparam logic [1:0]  BURST_CODE_32  = 2'h2;
   localparam logic [1:0]  BURST_CODE_64  = 2'h3;
   localparam logic [6:0]  BURST_BYTES_8  = 7'h08;
   localparam logic [6:0]  BURST_BYTES_16 = 7'h10;
   localparam logic [6:0]  BURST_BYTES_32 = 7'h20;
   localparam logic [6:0]  BURST_BYTES_64 = 7'h40;

   localparam logic [4:0]  LINK_BITS      = 5'h10;
   localparam logic [4:0]  SPI_STEP       = 5'h01;
   localparam logic [4:0]  QUAD_STEP      = 5'h04;

   typedef struct packed {
      logic       pinSel;
      logic [3:0] dummy;
      logic       wrapEn;
      logic [1:0] burstLen;
   } frpr_params_type;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] data;
   } frpr_word_type;

   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_RUN  = 2'b01
   } frpr_state_type;
endpackage

// >>> logic/frpr_link_rx.sv
// Serial-clock side receiver: command byte plus one data byte per frame
`timescale 1ns/100ps
`default_nettype none
module frpr_link_rx (
   input  wire logic                    sck,
   input  wire logic                    rst,
   input  wire logic                    csN,
   input  wire logic [3:0]              dataIn,
   input  wire logic                    quadCommandMode,
   output var frpr_pkg::frpr_word_type  wordOut,
   output logic                         wordToggle
);
   logic                    modeMeta_q;
   logic                    modeSync_q;
   logic [4:0]              bitCnt_q;
   logic [4:0]              bitCnt_d;
   logic [15:0]             shift_q;
   logic [15:0]             shift_d;
   frpr_pkg::frpr_word_type word_q;
   frpr_pkg::frpr_word_type word_d;
   logic                    tog_q;
   logic                    tog_d;
   logic                    frameRst;

   // Frame counters clear while chip select is high
   assign frameRst   = rst | csN;
   assign wordOut    = word_q;
   assign wordToggle = tog_q;

   // Mode level into the serial clock domain
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         modeMeta_q <= 1'b0;
         modeSync_q <= 1'b0;
      end else begin
         modeMeta_q <= quadCommandMode;
         modeSync_q <= modeMeta_q;
      end
   end

   always_comb begin
      bitCnt_d = bitCnt_q;
      shift_d  = shift_q;
      word_d   = word_q;
      tog_d    = tog_q;
      if (bitCnt_q != frpr_pkg::LINK_BITS) begin
         if (modeSync_q) begin
            shift_d  = {shift_q[11:0], dataIn};
            bitCnt_d = bitCnt_q + frpr_pkg::QUAD_STEP;
         end else begin
            shift_d  = {shift_q[14:0], dataIn[0]};
            bitCnt_d = bitCnt_q + frpr_pkg::SPI_STEP;
         end
         if (bitCnt_d == frpr_pkg::LINK_BITS) begin
            word_d = shift_d;
            tog_d  = ~tog_q;
         end
      end
   end

   always_ff @(posedge sck or posedge frameRst) begin
      if (frameRst) begin
         bitCnt_q <= 5'h00;
         shift_q  <= 16'h0000;
      end else begin
         bitCnt_q <= bitCnt_d;
         shift_q  <= shift_d;
      end
   end

   // Word and toggle survive the frame end for the crossing
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         word_q <= '0;
         tog_q  <= 1'b0;
      end else begin
         word_q <= word_d;
         tog_q  <= tog_d;
      end
   end
endmodule
`default_nettype wire

// >>> dv/frpr_host_model.sv
// Host-side serial controller model that drives the link pins
`timescale 1ns/100ps
`default_nettype none
module frpr_host_model (
   output logic       sck,
   output logic       csN,
   output logic [3:0] dataIn
);
   localparam int HALF_NS = 40;

   initial begin
      sck    = 1'b0;
      csN    = 1'b1;
      dataIn = 4'hA;
   end

   // Command then data, MSB first; fewer than 16 bits cuts the frame short
   task automatic send_frame(input logic [7:0] cmd,
                             input logic [7:0] data,
                             input logic       quad,
                             input int         nBits);
      logic [15:0] word;
      int          i;
      word = {cmd, data};
      #13;
      // Deselected lead-in clocks let the mode sync settle
      repeat (3) begin
         #(HALF_NS) sck = 1'b1;
         #(HALF_NS) sck = 1'b0;
      end
      csN = 1'b0;
      i = 0;
      while (i < nBits) begin
         if (quad) begin
            dataIn = word[15 - i -: 4];
            i = i + 4;
         end else begin
            dataIn = {~dataIn[3:1], word[15 - i]};
            i = i + 1;
         end
         // Period kept within the limit for any dummy setting
         #(HALF_NS) sck = 1'b1;
         #(HALF_NS) sck = 1'b0;
      end
      #(HALF_NS) csN = 1'b1;
      dataIn = ~dataIn;
   endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the read-parameter register pair
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                      clk_sys;
   logic                      rst;
   wire logic                 sck;
   wire logic                 csN;
   wire logic [3:0]           dataIn;
   logic                      quadEnableFlag;
   logic                      quadCommandMode;
   logic                      dedicatedResetDisable;
   logic                      readStart;
   logic [7:0]                readCmd;
   frpr_pkg::frpr_params_type nvParams;
   frpr_pkg::frpr_params_type vParams;
   logic                      loadBusy;
   logic                      writeDone;
   logic [3:0]                rdDummy;
   logic                      rdWrapEn;
   logic [6:0]                rdBurstBytes;
   logic                      rdRefused;
   logic                      sharedPinIsData3;
   logic                      sharedPinIsReset;
   frpr_pkg::frpr_params_type nvExp;
   frpr_pkg::frpr_params_type vExp;
   frpr_pkg::frpr_params_type d;
   integer                    seed = 32'h9A64;
   int                        n_mismatch = 0;
   int                        total_checks = 0;
   int                        cycles = 0;
   logic [7:0] rdCmds [12] = '{8'h0B, 8'h0D, 8'h3B, 8'hBB, 8'hBD, 8'h6B,
                               8'hEB, 8'hED, 8'hF1, 8'hF2, 8'hF3, 8'h5A};

   frpr_read_params #(.HAS_DEDICATED_RESET(1'b1)) u_frpr_read_params (
      .clk_sys(clk_sys), .rst(rst), .sck(sck), .csN(csN), .dataIn(dataIn),
      .quadEnableFlag(quadEnableFlag), .quadCommandMode(quadCommandMode),
      .dedicatedResetDisable(dedicatedResetDisable), .readStart(readStart),
      .readCmd(readCmd), .nvParams(nvParams), .vParams(vParams),
      .loadBusy(loadBusy), .writeDone(writeDone), .rdDummy(rdDummy),
      .rdWrapEn(rdWrapEn), .rdBurstBytes(rdBurstBytes), .rdRefused(rdRefused),
      .sharedPinIsData3(sharedPinIsData3), .sharedPinIsReset(sharedPinIsReset));

   frpr_host_model u_frpr_host_model (.sck(sck), .csN(csN), .dataIn(dataIn));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles >= 20000) begin
         n_mismatch++;
         $display("[ERR] %0t run did not finish", $time);
         final_report;
      end
   end

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   function automatic logic [3:0] exp_dummy(input logic [7:0] c, input logic q,
                                            input logic [3:0] f);
      logic [3:0] dd;
      if (c == 8'h0B || c == 8'h0D || c == 8'hF1 || c == 8'hF2 || c == 8'hF3) begin
         dd = q ? 4'h6 : 4'h8;
      end else if (c == 8'h3B || c == 8'h6B) begin
         dd = 4'h8;
      end else if (c == 8'hBB || c == 8'hBD) begin
         dd = 4'h4;
      end else if (c == 8'hEB || c == 8'hED) begin
         dd = 4'h6;
      end else begin
         return 4'h0;
      end
      if (q && c == 8'hBD) begin
         return 4'h0;
      end
      return (f != 4'h0) ? f : dd;
   endfunction

   task automatic link_write(input logic [7:0] c, input logic [7:0] v, input int nBits,
                             input logic expDone, input logic rdNow);
      logic seen;
      seen = 1'b0;
      u_frpr_host_model.send_frame(c, v, quadCommandMode, nBits);
      // Optional fast read started in the cycle the write is reported
      repeat (20) begin
         @(negedge clk_sys);
         readStart = rdNow && writeDone === 1'b1;
         readCmd   = 8'h0B;
         if (writeDone === 1'b1) begin
            seen = 1'b1;
         end
      end
      chk_bit(seen, expDone, "write completion");
   endtask

   task automatic read_chk(input logic [7:0] c);
      @(negedge clk_sys);
      readStart = 1'b1;
      readCmd   = c;
      @(negedge clk_sys);
      readStart = 1'b0;
      chk_rd(c);
   endtask

   task automatic chk_rd(input logic [7:0] c);
      chk_val({4'h0, rdDummy}, {4'h0, exp_dummy(c, quadCommandMode, vExp.dummy)},
              "dummy");
      chk_bit(rdRefused, quadCommandMode && c == 8'hBD, "refused");
      chk_val({1'b0, rdBurstBytes}, {1'b0, 7'h08 << vExp.burstLen}, "burst");
      chk_bit(rdWrapEn, vExp.wrapEn, "wrap");
   endtask

   task automatic write_v(input frpr_pkg::frpr_params_type v);
      link_write(($random(seed) & 1) ? 8'hC0 : 8'h63, v, 16, 1'b1, 1'b0);
      vExp = v;
   endtask

   initial begin
      rst = 1'b1;
      quadEnableFlag = 1'b0;
      quadCommandMode = 1'b0;
      dedicatedResetDisable = 1'b0;
      readStart = 1'b0;
      readCmd = 8'h00;
      nvExp = '0;
      vExp = '0;
      repeat (8) @(negedge clk_sys);
      chk_bit(loadBusy, 1'b1, "busy in reset");
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk_bit(loadBusy, 1'b0, "busy after load");
      chk_val(nvParams, 8'h00, "nv reset");
      chk_val(vParams, 8'h00, "v reset");
      read_chk(8'h0B);
      // Non-volatile write leaves the working copy alone
      d = 8'($random(seed));
      link_write(8'h65, d, 16, 1'b1, 1'b0);
      nvExp = d;
      chk_val(nvParams, nvExp, "nv write");
      chk_val(vParams, vExp, "v kept");
      read_chk(8'hEB);
      // Both volatile codes, then a read right after
      foreach (rdCmds[k]) begin
         if (k < 2) begin
            d = 8'($random(seed));
            link_write(k == 0 ? 8'hC0 : 8'h63, d, 16, 1'b1, 1'b1);
            vExp = d;
            chk_val(vParams, vExp, "v write");
            chk_val(nvParams, nvExp, "nv kept");
            chk_rd(8'h0B);
         end
      end
      // Foreign command and short frame are dropped
      link_write(8'h5A, 8'($random(seed)), 16, 1'b0, 1'b0);
      link_write(8'hC0, 8'($random(seed)), 8, 1'b0, 1'b0);
      chk_val(vParams, vExp, "v untouched");
      chk_val(nvParams, nvExp, "nv untouched");
      // Read setup sweep over modes, dummy field edges and every command
      for (int q = 0; q < 2; q++) begin
         quadCommandMode = q[0];
         repeat (4) @(negedge clk_sys);
         for (int f = 0; f < 3; f++) begin
            d = 8'($random(seed));
            d.dummy = (f == 0) ? 4'h0 : (f == 1) ? 4'hF : 4'(1 + {$random(seed)} % 14);
            write_v(d);
            foreach (rdCmds[k]) begin
               read_chk(rdCmds[k]);
            end
         end
      end
      // Shared pin function over select, quad flag, mode and reset-pin disable
      for (int i = 0; i < 16; i++) begin
         quadCommandMode = i[1];
         repeat (4) @(negedge clk_sys);
         d = vExp;
         d.pinSel = i[3];
         write_v(d);
         quadEnableFlag = i[2];
         dedicatedResetDisable = i[0];
         repeat (2) @(negedge clk_sys);
         chk_bit(sharedPinIsData3, i[2] | i[1], "pin data3");
         chk_bit(sharedPinIsReset, !(i[2] | i[1]) & i[3] & i[0], "pin reset");
      end
      // Second reset in mid-run
      rst = 1'b1;
      @(negedge clk_sys);
      chk_val(vParams, 8'h00, "v second reset");
      chk_val(nvParams, 8'h00, "nv second reset");
      rst = 1'b0;
      vExp = '0;
      repeat (2) @(negedge clk_sys);
      chk_bit(loadBusy, 1'b0, "busy after reload");
      read_chk(8'hBB);
      final_report;
   end
endmodule
`default_nettype wire
